// ---- logic/mri_reset_init.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Reset only after input held low longer than qualifying interval.
// - Reset clears every interrupt enable flag.
// - Reset clears the pending interrupt request flag.
// - Reset clears the halt flip-flop, leaving halt state.
// - Reset loads port B direction with all ones, all inputs.
// - Reset loads port C mode with all ones; outputs driven low.
// - Reset clears every status flag to zero.
// - Reset loads timer count with all ones, clears timer flip-flop.
// - Reset sets acknowledge latch and clears hold acknowledge.
// - Reset clears the program counter to zero.
// - Address, data bus and strobes float during reset.
// - After release, fetch begins at address zero.
// - Each port B direction bit: one input, zero output.
// - Port C mode bit set is plain I/O, clear is control function.
module mri_reset_init
   import mri_pkg::*;
#(
   parameter int QUAL_CYCLES = MRI_QUAL_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        dev_reset_n,
   input  wire logic        core_ie_set,
   input  wire logic [4:0]  core_ie_val,
   input  wire logic        core_irq_set,
   input  wire logic        core_halt_set,
   input  wire logic        core_dirb_wr,
   input  wire logic [7:0]  core_dirb_val,
   input  wire logic        core_modec_wr,
   input  wire logic [7:0]  core_modec_val,
   input  wire logic        core_flag_wr,
   input  wire logic [7:0]  core_flag_val,
   input  wire logic        core_tmr_wr,
   input  wire logic [11:0] core_tmr_val,
   input  wire logic        core_tmr_ff_set,
   input  wire logic        core_ack_clr,
   input  wire logic        core_hold_grant,
   input  wire logic        core_pc_load,
   input  wire logic [15:0] core_pc_val,
   input  wire logic        core_pc_inc,
   input  wire logic        core_bus_drive,
   input  wire logic [7:0]  core_data_out,
   input  wire logic        core_rd,
   input  wire logic        core_wr,
   input  wire logic [7:0]  portb_out_val,
   input  wire logic [7:0]  portc_out_val,
   input  wire logic [7:0]  portc_ctrl_val,
   output logic             init_active,
   output logic             fetch_start,
   output logic [4:0]       int_enable,
   output logic             int_request,
   output logic             halt_state,
   output logic [7:0]       portb_dir,
   output logic [7:0]       portb_oe_n,
   output logic [7:0]       portb_out,
   output logic [7:0]       portc_mode,
   output logic [7:0]       portc_out,
   output logic [7:0]       portc_oe_n,
   output logic [7:0]       status_flags,
   output logic [11:0]      timer_count,
   output logic             timer_ff,
   output logic             ack_latch,
   output logic             bus_grant_ack_latch,
   output logic [15:0]      program_counter,
   output logic [15:0]      wide_addr_out_lines,
   output logic             wide_addr_oe_n,
   output logic [7:0]       bidir_byte_bus_out,
   output logic             bidir_byte_bus_oe_n,
   output logic             rd_n_out,
   output logic             wr_n_out,
   output logic             strobe_oe_n
);

   // Qualifier counter is sixteen bits wide
   if (QUAL_CYCLES < 1 || QUAL_CYCLES > 65535) begin : g_bad_qual
      $error("QUAL_CYCLES out of range");
   end

   // ****************************************
   // Reset qualifier
   // ****************************************
   mri_state_t  state_q;
   logic [15:0] low_cnt_q;
   logic        in_rst;
   logic        rel_q;
   localparam logic [15:0] QUAL_LIM = 16'(QUAL_CYCLES);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_q <= 16'h0000;
      end else if (dev_reset_n) begin
         low_cnt_q <= 16'h0000;
      end else if (low_cnt_q != QUAL_LIM) begin
         low_cnt_q <= low_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= MRI_RUN;
      end else begin
         case (state_q)
            MRI_RUN: begin
               if (!dev_reset_n) begin
                  state_q <= MRI_QUAL;
               end
            end
            MRI_QUAL: begin
               if (dev_reset_n) begin
                  state_q <= MRI_RUN;
               end else if (low_cnt_q == QUAL_LIM) begin
                  state_q <= MRI_RESET;
               end
            end
            MRI_RESET: begin
               if (dev_reset_n) begin
                  state_q <= MRI_RUN;
               end
            end
            default: begin
               state_q <= MRI_RUN;
            end
         endcase
      end
   end

   assign in_rst      = (state_q == MRI_RESET);
   assign init_active = in_rst;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rel_q <= 1'b0;
      end else begin
         rel_q <= in_rst && dev_reset_n;
      end
   end
   assign fetch_start = rel_q;

   // ****************************************
   // Interrupt and halt state
   // ****************************************
   // clear enables
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         int_enable <= 5'h00;
      end else if (in_rst) begin
         int_enable <= 5'h00;
      end else if (core_ie_set) begin
         int_enable <= core_ie_val;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         int_request <= 1'b0;
      end else if (in_rst) begin
         int_request <= 1'b0;
      end else if (core_irq_set) begin
         int_request <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         halt_state <= 1'b0;
      end else if (in_rst) begin
         halt_state <= 1'b0;
      end else if (core_halt_set) begin
         halt_state <= 1'b1;
      end
   end

   // ****************************************
   // Port configuration
   // ****************************************
   // direction all inputs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         portb_dir <= MRI_DIRB_RST;
      end else if (in_rst) begin
         portb_dir <= MRI_DIRB_RST;
      end else if (core_dirb_wr) begin
         portb_dir <= core_dirb_val;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         portc_mode <= MRI_MODEC_RST;
      end else if (in_rst) begin
         portc_mode <= MRI_MODEC_RST;
      end else if (core_modec_wr) begin
         portc_mode <= core_modec_val;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         portb_out <= 8'h00;
         portc_out <= 8'h00;
      end else if (in_rst) begin
         portb_out <= 8'h00;
         portc_out <= 8'h00;
      end else begin
         portb_out <= portb_out_val;
         portc_out <= (portc_out_val & portc_mode) | (portc_ctrl_val & ~portc_mode);
      end
   end

   assign portb_oe_n = portb_dir;

   // Port C: lines 0,1,2,7 input when mode set; 2,7 control inputs
   localparam logic [7:0] PC_IN_PLAIN = 8'h87;
   localparam logic [7:0] PC_IN_CTRL  = 8'h84;
   assign portc_oe_n = (portc_mode & PC_IN_PLAIN) | (~portc_mode & PC_IN_CTRL);

   // ****************************************
   // Flags and timer
   // ****************************************
   // flags to zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_flags <= MRI_FLAG_RST;
      end else if (in_rst) begin
         status_flags <= MRI_FLAG_RST;
      end else if (core_flag_wr) begin
         status_flags <= core_flag_val;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timer_count <= MRI_TMR_RST;
         timer_ff    <= 1'b0;
      end else if (in_rst) begin
         timer_count <= MRI_TMR_RST;
         timer_ff    <= 1'b0;
      end else begin
         if (core_tmr_wr) begin
            timer_count <= core_tmr_val;
         end
         if (core_tmr_ff_set) begin
            timer_ff <= ~timer_ff;
         end
      end
   end

   // ****************************************
   // Bus ownership and program counter
   // ****************************************
   // ack set, hold ack clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_latch           <= 1'b1;
         bus_grant_ack_latch <= 1'b0;
      end else if (in_rst) begin
         ack_latch           <= 1'b1;
         bus_grant_ack_latch <= 1'b0;
      end else begin
         if (core_ack_clr) begin
            ack_latch <= 1'b0;
         end
         bus_grant_ack_latch <= core_hold_grant;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         program_counter <= MRI_PC_RST;
      end else if (in_rst) begin
         program_counter <= MRI_PC_RST;
      end else if (core_pc_load) begin
         program_counter <= core_pc_val;
      end else if (core_pc_inc) begin
         program_counter <= program_counter + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wide_addr_out_lines <= MRI_PC_RST;
         bidir_byte_bus_out  <= 8'h00;
         rd_n_out            <= 1'b1;
         wr_n_out            <= 1'b1;
      end else begin
         wide_addr_out_lines <= program_counter;
         bidir_byte_bus_out  <= core_data_out;
         rd_n_out            <= ~core_rd;
         wr_n_out            <= ~core_wr;
      end
   end

   assign wide_addr_oe_n      = in_rst || bus_grant_ack_latch;
   assign strobe_oe_n         = in_rst || bus_grant_ack_latch;
   assign bidir_byte_bus_oe_n = in_rst || bus_grant_ack_latch || !core_bus_drive;

endmodule

// ---- logic/mri_pkg.sv ----
package mri_pkg;
   // ****************************************
   // Widths and timing
   // ****************************************
   localparam int  MRI_CLK_HZ        = 40_000_000;
   localparam int  MRI_QUAL_TIME_NS  = 4000;
   // Least time, rounded up to whole cycles
   localparam int  MRI_QUAL_CYCLES   = (MRI_QUAL_TIME_NS * (MRI_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int  MRI_ADDR_W        = 16;
   localparam int  MRI_DATA_W        = 8;
   localparam int  MRI_TMR_W         = 12;
   localparam int  MRI_FLAG_W        = 8;
   localparam int  MRI_IE_W          = 5;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0]  MRI_DIRB_RST  = 8'hFF;
   localparam logic [7:0]  MRI_MODEC_RST = 8'hFF;
   localparam logic [11:0] MRI_TMR_RST   = 12'hFFF;
   localparam logic [15:0] MRI_PC_RST    = 16'h0000;
   localparam logic [7:0]  MRI_FLAG_RST  = 8'h00;

   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [1:0] {
      MRI_RUN   = 2'b00,
      MRI_QUAL  = 2'b01,
      MRI_RESET = 2'b11
   } mri_state_t;
endpackage

// ---- dv/mri_reset_init_props.sv ----
`timescale 1ns/1ps
// ***
// Reset qualifier and init checks
// ***
module mri_reset_init_chk
   import mri_pkg::*;
#(
   parameter int QUAL_CYCLES = MRI_QUAL_CYCLES
) (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        dev_reset_n,
   input wire logic        init_active,
   input wire logic        fetch_start,
   input wire logic [4:0]  int_enable,
   input wire logic        int_request,
   input wire logic        halt_state,
   input wire logic [7:0]  portb_dir,
   input wire logic [7:0]  portb_oe_n,
   input wire logic [7:0]  portc_mode,
   input wire logic [7:0]  status_flags,
   input wire logic [11:0] timer_count,
   input wire logic        timer_ff,
   input wire logic        ack_latch,
   input wire logic        bus_grant_ack_latch,
   input wire logic [15:0] program_counter,
   input wire logic        wide_addr_oe_n,
   input wire logic        bidir_byte_bus_oe_n,
   input wire logic        strobe_oe_n,
   input wire logic        core_rd,
   input wire logic        core_wr,
   input wire logic [7:0]  core_data_out,
   input wire logic [7:0]  portb_out_val,
   input wire logic [7:0]  portc_out_val,
   input wire logic [7:0]  portc_ctrl_val,
   input wire logic [7:0]  portb_out,
   input wire logic [7:0]  portc_out,
   input wire logic [7:0]  portc_oe_n,
   input wire logic [15:0] wide_addr_out_lines,
   input wire logic [7:0]  bidir_byte_bus_out,
   input wire logic        rd_n_out,
   input wire logic        wr_n_out
);
   int lo_q;
   // Consecutive low samples, saturating
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lo_q <= 0;
      end else if (dev_reset_n) begin
         lo_q <= 0;
      end else if (lo_q <= QUAL_CYCLES) begin
         lo_q <= lo_q + 1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_held;
      init_active ##1 init_active;
   endsequence
   property p_qual_min; init_active |-> lo_q > QUAL_CYCLES; endproperty
   property p_qual_max; lo_q == QUAL_CYCLES + 1 |-> init_active; endproperty
   property p_release; init_active && dev_reset_n |=> !init_active && fetch_start; endproperty
   property p_fetch_pc; fetch_start |-> program_counter == MRI_PC_RST; endproperty
   property p_fetch_once; fetch_start |=> !fetch_start; endproperty
   property p_float;
      init_active |-> wide_addr_oe_n && bidir_byte_bus_oe_n && strobe_oe_n;
   endproperty
   property p_irq; s_held |-> int_enable == 5'h00 && !int_request && !halt_state; endproperty
   property p_ports;
      s_held |-> portb_dir == MRI_DIRB_RST && portb_oe_n == 8'hFF && portc_mode == MRI_MODEC_RST;
   endproperty
   property p_timer;
      s_held |-> timer_count == MRI_TMR_RST && !timer_ff && status_flags == MRI_FLAG_RST;
   endproperty
   property p_ack; s_held |-> ack_latch && !bus_grant_ack_latch; endproperty
   // Address bus driven, then shows zero
   sequence s_fetch_zero;
      !wide_addr_oe_n ##1 wide_addr_out_lines == MRI_PC_RST;
   endsequence
   property p_fetch_addr; fetch_start |-> s_fetch_zero; endproperty
   property p_drive;
      !init_active && !bus_grant_ack_latch |-> !wide_addr_oe_n && !strobe_oe_n;
   endproperty
   property p_strobe;
      1'b1 |=> rd_n_out == !$past(core_rd) && wr_n_out == !$past(core_wr)
         && bidir_byte_bus_out == $past(core_data_out);
   endproperty
   property p_dirb; portb_oe_n == portb_dir; endproperty
   // Lines 3..6 always driven, 2 and 7 always inputs, 0 and 1 by mode
   property p_portc_oe;
      portc_oe_n[6:3] == 4'h0 && portc_oe_n[2] && portc_oe_n[7]
         && portc_oe_n[1:0] == portc_mode[1:0];
   endproperty
   property p_port_out;
      !init_active |=> portb_out == $past(portb_out_val)
         && portc_out == (($past(portc_out_val) & $past(portc_mode))
         | ($past(portc_ctrl_val) & ~$past(portc_mode)));
   endproperty
   a_qual_min: assert property (p_qual_min) else $error("reset too early");
   a_qual_max: assert property (p_qual_max) else $error("reset too late");
   a_release: assert property (p_release) else $error("bad release");
   a_fetch_pc: assert property (p_fetch_pc) else $error("fetch not at zero");
   a_fetch_once: assert property (p_fetch_once) else $error("long fetch pulse");
   a_float: assert property (p_float) else $error("bus driven in reset");
   a_irq: assert property (p_irq) else $error("irq state kept");
   a_ports: assert property (p_ports) else $error("port modes wrong");
   a_timer: assert property (p_timer) else $error("timer or flags wrong");
   a_ack: assert property (p_ack) else $error("ack latches wrong");
   a_fetch_addr: assert property (p_fetch_addr) else $error("first fetch not at zero");
   a_drive: assert property (p_drive) else $error("bus floated outside reset");
   a_strobe: assert property (p_strobe) else $error("strobe or data late");
   a_dirb: assert property (p_dirb) else $error("port B direction wrong");
   a_portc_oe: assert property (p_portc_oe) else $error("port C direction wrong");
   a_port_out: assert property (p_port_out) else $error("port output wrong");
endmodule
bind mri_reset_init mri_reset_init_chk #(.QUAL_CYCLES(QUAL_CYCLES)) i_chk (.*);

// ---- dv/mri_rst_src.sv ----
`timescale 1ns/1ps
// ***
// External reset source
// ***
module mri_rst_src (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [7:0] len,
   output logic            dev_reset_n,
   output logic            done
);
   logic [7:0] cnt_q = 8'h00;
   always @(posedge clk) begin
      done <= !go && (cnt_q == 8'h01);
      if (go) begin
         cnt_q <= len;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
   assign dev_reset_n = (cnt_q == 8'h00);
endmodule

// ---- dv/mri_reset_init_test.sv ----
`timescale 1ns/1ps
module mri_reset_init_test;
   import mri_pkg::*;
   localparam int QUAL = 4;
   localparam logic [69:0] RST_ST = {5'h00, 2'h0, MRI_DIRB_RST, MRI_MODEC_RST,
      MRI_FLAG_RST, MRI_TMR_RST, 3'h2, MRI_PC_RST, 8'h00};
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        core_ie_set, core_irq_set, core_halt_set, core_dirb_wr, core_modec_wr;
   logic        core_flag_wr, core_tmr_wr, core_tmr_ff_set, core_ack_clr, core_hold_grant;
   logic        core_pc_load, core_pc_inc, core_bus_drive, core_rd, core_wr, init_active;
   logic        fetch_start, int_request, halt_state, timer_ff, ack_latch, bus_grant_ack_latch;
   logic        wide_addr_oe_n, bidir_byte_bus_oe_n, rd_n_out, wr_n_out, strobe_oe_n;
   logic        dev_reset_n, src_go, src_done;
   logic [4:0]  core_ie_val, int_enable;
   logic [7:0]  core_dirb_val, core_modec_val, core_flag_val, core_data_out, portb_out_val;
   logic [7:0]  portc_out_val, portc_ctrl_val, portb_dir, portb_oe_n, portb_out, portc_mode;
   logic [7:0]  portc_out, portc_oe_n, status_flags, bidir_byte_bus_out, src_len;
   logic [11:0] core_tmr_val, timer_count;
   logic [15:0] core_pc_val, program_counter, wide_addr_out_lines;
   logic [103:0] rnd = '0;
   logic [69:0] exp_q[$];
   int          fail_count = 0;
   int          num_checks = 0;
   assign {core_ie_set, core_ie_val, core_irq_set, core_halt_set, core_dirb_wr, core_dirb_val,
      core_modec_wr, core_modec_val, core_flag_wr, core_flag_val, core_tmr_wr, core_tmr_val,
      core_tmr_ff_set, core_ack_clr, core_hold_grant, core_pc_load, core_pc_val, core_pc_inc,
      core_bus_drive, core_data_out, core_rd, core_wr, portb_out_val, portc_out_val,
      portc_ctrl_val} = rnd;
   mri_reset_init #(.QUAL_CYCLES(QUAL)) i_dut (.*);
   mri_rst_src i_src (.clk(clk), .go(src_go), .len(src_len), .dev_reset_n(dev_reset_n),
      .done(src_done));
   always #12.5 clk = ~clk;
   // Core activity never pauses
   always @(posedge clk) begin
      rnd <= 104'({$urandom, $urandom, $urandom, $urandom});
   end
   task automatic cmp(input string name, input logic [69:0] exp, input logic [69:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic pulse(input logic [7:0] n, input bit hit, input int gap);
      int k;
      if (hit) exp_q.push_back(RST_ST);
      src_len <= n;
      src_go  <= 1'b1;
      @(posedge clk);
      src_go <= 1'b0;
      k = 0;
      while (src_done !== 1'b1 && k < 300) begin
         @(posedge clk);
         k++;
      end
      if (k == 300) begin
         fail_count++;
         end_of_test();
      end
      repeat (gap) @(posedge clk);
   endtask
   // State seen in the fetch cycle
   always @(posedge clk) begin
      if (fetch_start === 1'b1) begin
         cmp("state", exp_q.size() > 0 ? exp_q.pop_front() : '1, {int_enable, int_request,
            halt_state, portb_dir, portc_mode, status_flags, timer_count, timer_ff, ack_latch,
            bus_grant_ack_latch, program_counter, portc_out});
      end
   end
   initial begin
      void'($urandom(32'h4BA5));
      src_go  = 1'b0;
      src_len = 8'h00;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      pulse(8'(QUAL), 1'b0, 0);
      pulse(8'(QUAL), 1'b0, 12);
      pulse(8'(QUAL + 2), 1'b1, 12);
      pulse(8'(QUAL + 3 + $urandom_range(30)), 1'b1, 12);
      pulse(8'h01, 1'b0, 12);
      cmp("pending", 70'h0, 70'(exp_q.size()));
      end_of_test();
   end
endmodule
